// *** burst_counter.sv ***
// Port burst address counter with bus-matching sub-counter
`timescale 1ns/100ps
module burst_counter (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire dp_port_pkg::cnt_op_t          op,
    input  wire logic [dp_port_pkg::ADDR_W-1:0] extAddr,
    input  wire dp_port_pkg::width_t           width,
    input  wire logic                          bigEndian,
    output logic [dp_port_pkg::ADDR_W-1:0]     wordNxt,
    output logic [1:0]                         subNxt,
    output logic [dp_port_pkg::ADDR_W-1:0]     word_r,
    output logic [1:0]                         sub_r
);
    logic [1:0] subStart;
    logic [1:0] subEnd;
    logic [1:0] subMax;

    always_comb begin
        subMax   = (width == dp_port_pkg::WIDTH9)  ? dp_port_pkg::SUB_LAST_9 :
                   (width == dp_port_pkg::WIDTH18) ? dp_port_pkg::SUB_LAST_18 : dp_port_pkg::SUB_FIRST;
        // Big-endian order walks the lanes downward
        subStart = bigEndian ? subMax : dp_port_pkg::SUB_FIRST;
        subEnd   = bigEndian ? dp_port_pkg::SUB_FIRST : subMax;
        wordNxt  = word_r;
        subNxt   = sub_r;
        case (op)
            dp_port_pkg::CNT_CLEAR: begin
                wordNxt = dp_port_pkg::ADDR_RESET;
                subNxt  = subStart;
            end
            dp_port_pkg::CNT_LOAD: begin
                wordNxt = extAddr;
                subNxt  = subStart;
            end
            dp_port_pkg::CNT_STEP: begin
                if (sub_r == subEnd) begin
                    wordNxt = word_r + 1'b1;
                    subNxt  = subStart;
                end else begin
                    subNxt = bigEndian ? sub_r - 1'b1 : sub_r + 1'b1;
                end
            end
            default: begin
                wordNxt = word_r;
                subNxt  = sub_r;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            word_r <= dp_port_pkg::ADDR_RESET;
            sub_r  <= dp_port_pkg::SUB_FIRST;
        end else begin
            word_r <= wordNxt;
            sub_r  <= subNxt;
        end
    end
endmodule : burst_counter

// *** dp_port_ctrl.sv ***
// One synchronous port of a 36-bit dual-port RAM with burst counter and bus matching
`timescale 1ns/100ps
module dp_port_ctrl #(
    parameter int ADDR_W     = dp_port_pkg::ADDR_W,
    parameter int FIFO_DEPTH = dp_port_pkg::FIFO_DEPTH
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          chipSelectN,
    input  wire logic                          readWriteN,
    input  wire logic                          outputEnableN,
    input  wire logic                          address_strobe_n,
    input  wire logic                          count_advance_n,
    input  wire logic                          counter_clear_n,
    input  wire logic                          width_reduce_enable,
    input  wire logic                          widthSelect,
    input  wire logic                          lane_order_select,
    input  wire logic                          output_register_select,
    input  wire logic                          lane0_select_n,
    input  wire logic                          lane1_select_n,
    input  wire logic                          lane2_select_n,
    input  wire logic                          lane3_select_n,
    input  wire logic [ADDR_W-1:0]             addrIn,
    input  wire logic [dp_port_pkg::WORD_W-1:0] dataIn,
    output logic [dp_port_pkg::WORD_W-1:0]     dataOut,
    output logic [dp_port_pkg::WORD_W-1:0]     dataOe,
    output logic                               writeReady
);
    localparam int W  = dp_port_pkg::WORD_W;
    localparam int LW = dp_port_pkg::LANE_W;
    localparam int EW = dp_port_pkg::WR_ENTRY_W;

    // ------------------------------------------------------------
    // Configuration and storage
    // ------------------------------------------------------------
    logic [W-1:0]           mem [2**ADDR_W];
    dp_port_pkg::width_t    width_r;
    logic                   bigEndian_r;
    dp_port_pkg::cnt_op_t   cntOp;
    logic [ADDR_W-1:0]      wordNxt;
    logic [1:0]             subNxt;
    logic [ADDR_W-1:0]      word_r;
    logic [1:0]             sub_r;
    logic                   readNow;
    logic                   writeNow;
    logic                   readbackNow;
    logic [1:0]             rbBeats_r;
    logic [3:0]             laneMask;
    logic [W-1:0]           laneData;
    logic [W-1:0]           fmtData;
    logic [W-1:0]           fmtLanes;
    logic [W-1:0]           stageData_r;
    logic [W-1:0]           stageLanes_r;
    logic                   stageDrive_r;
    logic [W-1:0]           dataOut_r;
    logic [W-1:0]           laneOe_r;
    logic                   drive_r;
    logic                   writeReady_r;
    logic [W-1:0]           rdWord;

    stream_if #(.W(EW)) wrFill ();
    stream_if #(.W(EW)) wrDrain ();

    // Width takes effect one edge after the pins change
    always_ff @(posedge clk) begin
        if (!resetn) begin
            width_r     <= dp_port_pkg::WIDTH36;
            bigEndian_r <= 1'b0;
        end else begin
            if (!width_reduce_enable) begin
                width_r <= dp_port_pkg::WIDTH36;
            end else if (widthSelect) begin
                width_r <= dp_port_pkg::WIDTH9;
            end else begin
                width_r <= dp_port_pkg::WIDTH18;
            end
            bigEndian_r <= lane_order_select & width_reduce_enable;
        end
    end

    // ------------------------------------------------------------
    // Counter control decode (chip select plays no part)
    // ------------------------------------------------------------
    always_comb begin
        if (!counter_clear_n) begin
            cntOp = dp_port_pkg::CNT_CLEAR;
        end else if (!address_strobe_n && !count_advance_n) begin
            cntOp = dp_port_pkg::CNT_LOAD;
        end else if (!address_strobe_n && readWriteN) begin
            cntOp = dp_port_pkg::CNT_READBACK;
        end else if (!count_advance_n) begin
            cntOp = dp_port_pkg::CNT_STEP;
        end else begin
            cntOp = dp_port_pkg::CNT_HOLD;
        end
    end

    burst_counter u_counter (
        .clk       (clk),
        .resetn    (resetn),
        .op        (cntOp),
        .extAddr   (addrIn),
        .width     (width_r),
        .bigEndian (bigEndian_r),
        .wordNxt   (wordNxt),
        .subNxt    (subNxt),
        .word_r    (word_r),
        .sub_r     (sub_r)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // Access proceeds in the same edge as a counter clear
    assign readNow     = !chipSelectN && readWriteN;
    assign writeNow    = !chipSelectN && !readWriteN;
    assign readbackNow = readNow && (cntOp == dp_port_pkg::CNT_READBACK);

    // ------------------------------------------------------------
    // Lane steering for writes and reads
    // ------------------------------------------------------------
    always_comb begin
        laneMask = 4'h0;
        laneData = dataIn;
        fmtLanes = '0;
        rdWord   = mem[wordNxt];
        fmtData  = '0;
        case (width_r)
            dp_port_pkg::WIDTH18: begin
                laneMask = subNxt[0] ? 4'hc : 4'h3;
                laneData = {2{dataIn[2*LW-1:0]}};
                fmtData[2*LW-1:0] = subNxt[0] ? rdWord[W-1:2*LW] : rdWord[2*LW-1:0];
                fmtLanes[2*LW-1:0] = '1;
            end
            dp_port_pkg::WIDTH9: begin
                laneMask = 4'h1 << subNxt;
                laneData = {4{dataIn[LW-1:0]}};
                fmtData[LW-1:0] = rdWord[subNxt*LW +: LW];
                fmtLanes[LW-1:0] = '1;
            end
            default: begin
                laneMask = ~{lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n};
                fmtData  = rdWord;
                fmtLanes = '1;
            end
        endcase
        if (readbackNow) begin
            fmtData = '0;
            case (width_r)
                dp_port_pkg::WIDTH36: begin
                    fmtData[dp_port_pkg::RB_POS_36 +: ADDR_W] = word_r;
                end
                dp_port_pkg::WIDTH18: begin
                    fmtData[dp_port_pkg::RB_POS_18 +: ADDR_W+1] = {word_r, sub_r[0]};
                end
                default: begin
                    // High part is shown for two beats, then the low part
                    if (rbBeats_r < dp_port_pkg::RB_HI_BEATS) begin
                        fmtData[LW-1:0] = word_r[ADDR_W-1:dp_port_pkg::RB_HI_LSB];
                    end else begin
                        fmtData[LW-1:1] = {sub_r, word_r[dp_port_pkg::RB_LO_BITS-1:0]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Readback beat count
    // ------------------------------------------------------------
    // Saturates so a held readback stays on the low part
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rbBeats_r <= 2'h0;
        end else if (readbackNow) begin
            rbBeats_r <= (rbBeats_r == 2'h3) ? rbBeats_r : rbBeats_r + 1'b1;
        end else begin
            rbBeats_r <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Write path through the FIFO
    // ------------------------------------------------------------
    assign wrFill.valid = writeNow;
    assign wrFill.data  = {wordNxt, laneMask, laneData};
    // Array port is shared; a read in this cycle stalls the drain
    assign wrDrain.ready = !readNow;

    sync_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clk    (clk),
        .resetn (resetn),
        .fill   (wrFill.sink),
        .drain  (wrDrain.source)
    );

    // ------------------------------------------------------------
    // Array update
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wrDrain.valid && wrDrain.ready) begin
            for (int i = 0; i < dp_port_pkg::LANES; i++) begin
                if (wrDrain.data[W+i]) begin
                    mem[wrDrain.data[EW-1 -: ADDR_W]][i*LW +: LW] <= wrDrain.data[i*LW +: LW];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            writeReady_r <= 1'b1;
        end else begin
            writeReady_r <= wrFill.ready;
        end
    end

    // ------------------------------------------------------------
    // Output timing: flow-through and pipelined
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stageData_r <= '0;
        end else begin
            stageData_r <= fmtData;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stageLanes_r <= '0;
        end else begin
            stageLanes_r <= fmtLanes;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stageDrive_r <= 1'b0;
        end else begin
            stageDrive_r <= readNow;
        end
    end

    // Drive state comes from the controls of the cycle before, or of two cycles before when pipelined
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataOut_r <= '0;
        end else if (output_register_select) begin
            dataOut_r <= stageData_r;
        end else begin
            dataOut_r <= fmtData;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            laneOe_r <= '0;
        end else if (output_register_select) begin
            laneOe_r <= stageLanes_r;
        end else begin
            laneOe_r <= fmtLanes;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_r <= 1'b0;
        end else if (output_register_select) begin
            drive_r <= stageDrive_r;
        end else begin
            drive_r <= readNow;
        end
    end

    assign dataOut    = dataOut_r;
    // Output enable bypasses the clock on purpose
    assign dataOe     = drive_r && !outputEnableN ? laneOe_r : '0;
    assign writeReady = writeReady_r;
endmodule : dp_port_ctrl

// *** dp_port_ctrl_sva.sv ***
// Concurrent checks on the pins of one dual-port RAM port
`timescale 1ns/100ps
module dp_port_ctrl_sva #(
    parameter int ADDR_W     = 15,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic                          clk,
    input wire logic                          resetn,
    input wire logic                          chipSelectN,
    input wire logic                          readWriteN,
    input wire logic                          outputEnableN,
    input wire logic                          address_strobe_n,
    input wire logic                          count_advance_n,
    input wire logic                          counter_clear_n,
    input wire logic                          width_reduce_enable,
    input wire logic                          output_register_select,
    input wire logic [ADDR_W-1:0]             addrIn,
    input wire logic [dp_port_pkg::WORD_W-1:0] dataOut,
    input wire logic [dp_port_pkg::WORD_W-1:0] dataOe
);
    // Counter checks only in full width, flow-through, where readback is one beat
    logic flow36;
    assign flow36 = !width_reduce_enable && !output_register_select;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Counter operations
    // ------------------------------------------------------------
    sequence s_load;  flow36 && counter_clear_n && !address_strobe_n && !count_advance_n; endsequence
    sequence s_step;  flow36 && counter_clear_n && address_strobe_n && !count_advance_n; endsequence
    sequence s_hold;  flow36 && counter_clear_n && address_strobe_n && count_advance_n; endsequence
    sequence s_rback;
        flow36 && counter_clear_n && !address_strobe_n && count_advance_n && readWriteN && !chipSelectN;
    endsequence

    a_oe_gate:
        assert property (outputEnableN |-> dataOe == '0) else $error("drive enable set with output enable off");
    a_flow_deselect:
        assert property (chipSelectN && !output_register_select |=> dataOe == '0) else $error("deselect kept drive");
    a_pipe_deselect:
        assert property (chipSelectN && output_register_select |-> ##2 dataOe == '0) else $error("late deselect");
    a_write_float:
        assert property (!chipSelectN && !readWriteN && !output_register_select |=> dataOe == '0)
        else $error("write cycle followed by drive");
    a_read_drive:
        assert property (!chipSelectN && readWriteN && !count_advance_n && flow36 ##1 !outputEnableN |-> dataOe == '1)
        else $error("read cycle not driven");
    a_clear_read:
        assert property (!counter_clear_n && !chipSelectN && readWriteN && flow36 ##1 !outputEnableN |-> dataOe == '1)
        else $error("read lost during counter clear");
    a_load_readback:
        assert property (s_load ##1 s_rback |=> dataOut[17:3] == $past(addrIn, 2)) else $error("load not seen");
    a_clear_first:
        assert property (!counter_clear_n && flow36 ##1 s_rback |=> dataOut[17:3] == '0) else $error("clear missed");
    a_step_up:
        assert property (s_load ##1 s_step ##1 s_rback |=> dataOut[17:3] == $past(addrIn, 3) + 1'b1)
        else $error("step did not add one");
    a_hold_still:
        assert property (s_load ##1 s_hold ##1 s_rback |=> dataOut[17:3] == $past(addrIn, 3))
        else $error("hold moved the counter");
endmodule : dp_port_ctrl_sva

bind dp_port_ctrl dp_port_ctrl_sva #(.ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH)) chk (
    .clk, .resetn, .chipSelectN, .readWriteN, .outputEnableN, .address_strobe_n, .count_advance_n,
    .counter_clear_n, .width_reduce_enable, .output_register_select, .addrIn, .dataOut, .dataOe);

// *** dp_port_pkg.sv ***
// Shared constants and types for the dual-port RAM port control
package dp_port_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int WORD_W      = 36;
    localparam int ADDR_W      = 15;
    localparam int LANE_W      = 9;
    localparam int LANES       = 4;
    localparam int SUB_W       = 2;
    localparam int FIFO_DEPTH  = 32;
    localparam int WR_ENTRY_W  = ADDR_W + LANES + WORD_W;

    // ------------------------------------------------------------
    // Sub-counter start and end points
    // ------------------------------------------------------------
    localparam logic [1:0] SUB_FIRST   = 2'h0;
    localparam logic [1:0] SUB_LAST_18 = 2'h1;
    localparam logic [1:0] SUB_LAST_9  = 2'h3;

    // ------------------------------------------------------------
    // Counter address placement on the data lines during readback
    // ------------------------------------------------------------
    localparam int RB_POS_36   = 3;
    localparam int RB_POS_18   = 2;
    localparam int RB_HI_LSB   = 6;
    localparam int RB_LO_BITS  = 6;
    localparam logic [1:0] RB_HI_BEATS = 2'h2;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

    typedef enum logic [1:0] {WIDTH36, WIDTH18, WIDTH9} width_t;
    typedef enum logic [2:0] {CNT_CLEAR, CNT_LOAD, CNT_READBACK, CNT_HOLD, CNT_STEP} cnt_op_t;
endpackage : dp_port_pkg

// *** host_model.sv ***
// Host side of one port: every control changes just after a rising edge
`timescale 1ns/100ps
module host_model (
    input  wire logic                      clk,
    output logic                           chipSelectN,
    output logic                           readWriteN,
    output logic                           outputEnableN,
    output logic                           address_strobe_n,
    output logic                           count_advance_n,
    output logic                           counter_clear_n,
    output logic [3:0]                     cfg,
    output logic [3:0]                     laneSelN,
    output logic [dp_port_pkg::ADDR_W-1:0] addrIn,
    output logic [dp_port_pkg::WORD_W-1:0] dataIn
);
    initial begin
        {chipSelectN, readWriteN, address_strobe_n, count_advance_n, counter_clear_n} = 5'h1f;
        outputEnableN = 1'b0;
        cfg = 4'h0;
        laneSelN = 4'h0;
        addrIn = '0;
        dataIn = '0;
    end

    // Control order: select, read/write, strobe, count, clear
    task automatic beat(input logic [4:0] ctl, input logic [dp_port_pkg::ADDR_W-1:0] a,
                        input logic [dp_port_pkg::WORD_W-1:0] d, input logic [3:0] ln, input logic oeN);
        @(posedge clk);
        {chipSelectN, readWriteN, address_strobe_n, count_advance_n, counter_clear_n} <= ctl;
        addrIn <= a;
        dataIn <= d;
        laneSelN <= ln;
        outputEnableN <= oeN;
    endtask : beat

    // Width and mode change only between idle stretches, never mid-burst
    task automatic setup(input logic [3:0] c);
        @(posedge clk);
        cfg <= c;
    endtask : setup
endmodule : host_model

// *** stream_if.sv ***
// Valid/ready carrier between the port logic and its write FIFO
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : stream_if

// *** sync_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic clk,
    input  wire logic resetn,
    stream_if.sink    fill,
    stream_if.source  drain
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    assign fill.ready  = (count_r != (PW+1)'(DEPTH));
    assign drain.valid = (count_r != '0);
    assign drain.data  = store[rdPtr_r];
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_r] <= fill.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : sync_fifo

// *** tb_dp_port_ctrl.sv ***
// Self-checking bench for one synchronous dual-port RAM port
`timescale 1ns/100ps
module tb_dp_port_ctrl;
    typedef logic [dp_port_pkg::WORD_W-1:0] word_t;
    typedef logic [dp_port_pkg::ADDR_W-1:0] addr_t;
    typedef struct {int due; word_t dm; word_t dv; word_t om; word_t ov;} note_t;
    localparam word_t RB36 = 36'h00003fff8;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        chipSelectN, readWriteN, outputEnableN, address_strobe_n, count_advance_n, counter_clear_n;
    logic        writeReady;
    logic [3:0]  cfg, laneSelN;
    addr_t       addrIn, a;
    word_t       dataIn, dataOut, dataOe;
    note_t       notes[$];
    note_t       nt;
    word_t       mem [int];
    addr_t       ad [8];
    logic [31:0] seed = 32'h00000017;
    int          cyc = 0;
    int          lat = 2;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #12.5 clk = ~clk;

    host_model host (.clk, .chipSelectN, .readWriteN, .outputEnableN, .address_strobe_n, .count_advance_n,
                     .counter_clear_n, .cfg, .laneSelN, .addrIn, .dataIn);

    dp_port_ctrl dut (.clk, .resetn, .chipSelectN, .readWriteN, .outputEnableN, .address_strobe_n,
                      .count_advance_n, .counter_clear_n, .width_reduce_enable(cfg[3]), .widthSelect(cfg[2]),
                      .lane_order_select(cfg[1]), .output_register_select(cfg[0]), .lane0_select_n(laneSelN[0]),
                      .lane1_select_n(laneSelN[1]), .lane2_select_n(laneSelN[2]), .lane3_select_n(laneSelN[3]),
                      .addrIn, .dataIn, .dataOut, .dataOe, .writeReady);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic word_t at3(input addr_t v);
        return word_t'(v) << 3;
    endfunction : at3

    task automatic cmp_word(input string nm, input word_t m, input word_t e, input word_t g);
        samples_checked++;
        if (((g ^ e) & m) !== '0) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e & m, g & m);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask : cmp_bit

    // Outputs for a request taken at the next edge appear lat negedges on
    task automatic note(input int l, input word_t dm, input word_t dv, input word_t om, input word_t ov);
        notes.push_back('{cyc + l, dm, dv, om, ov});
    endtask : note

    task automatic off(input logic [4:0] c, input addr_t x);
        host.beat(c, x, '0, 4'h0, 1'b0);
        note(lat, '0, '0, '1, '0);
    endtask : off

    task automatic idle(input int n);
        repeat (n) off(5'h1f, '0);
    endtask : idle

    task automatic wr(input addr_t x, input word_t d, input logic [3:0] ln, input logic oeN);
        host.beat(5'h01, x, d, ln, oeN);
        for (int i = 0; i < 4; i++)
            if (!ln[i]) mem[x][9*i +: 9] = d[9*i +: 9];
        note(lat, '0, '0, '1, '0);
    endtask : wr

    task automatic rd(input addr_t x);
        host.beat(5'h09, x, word_t'({rnd(), rnd()}), 4'h0, 1'b0);
        note(lat, '1, mem[x], '1, '1);
    endtask : rd

    // External address is random: readback must ignore it
    task automatic rb(input word_t m, input word_t v);
        host.beat(5'h0b, addr_t'(rnd()), '0, 4'h0, 1'b0);
        note(lat, m, v, '0, '0);
    endtask : rb

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask : done

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(negedge clk) begin
        cyc++;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            nt = notes.pop_front();
            cmp_word("dataOut", nt.dm, nt.dv, dataOut);
            cmp_word("dataOe", nt.om, nt.ov, dataOe);
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        cmp_word("dataOe", '1, '0, dataOe);
        cmp_bit("writeReady", 1'b1, writeReady);
        foreach (ad[i]) ad[i] = addr_t'(rnd());
        foreach (ad[i]) wr(ad[i], word_t'({rnd(), rnd()}), 4'h0, 1'b0);
        foreach (ad[i]) wr(ad[i], word_t'({rnd(), rnd()}), 4'(rnd()), 1'b1);
        // Queued writes drain only in cycles without a read
        idle(6);
        foreach (ad[i]) rd(ad[i]);
        done("write and read");
        for (int i = 0; i < 6; i++) begin
            host.beat(5'h09, ad[i], '0, 4'h0, i[0]);
            note(lat, '1, mem[ad[i]], '1, i[0] ? '1 : '0);
        end
        idle(2);
        done("output enable");
        a = addr_t'(rnd());
        off(5'h19, a);
        off(5'h1d, '0);
        off(5'h1d, '0);
        off(5'h1f, addr_t'(rnd()));
        rb(RB36, at3(a + 2'h2));
        rb(RB36, at3(a + 2'h2));
        host.beat(5'h08, a, '0, 4'h0, 1'b0);
        note(lat, '0, '0, '1, '1);
        rb(RB36, '0);
        off(5'h19, a);
        rb(RB36, at3(a));
        off(5'h19, a);
        off(5'h1d, '0);
        rb(RB36, at3(a + 1'b1));
        off(5'h19, a);
        off(5'h1f, '0);
        rb(RB36, at3(a));
        idle(2);
        done("counter");
        host.setup(4'hc);
        idle(3);
        off(5'h19, a);
        repeat (2) rb(36'h1ff, word_t'(a[14:6]));
        rb(36'h1fe, word_t'(a[5:0]) << 1);
        idle(2);
        host.setup(4'ha);
        idle(3);
        off(5'h19, a);
        rb(36'h3fffc, word_t'({a, 1'b1}) << 2);
        off(5'h1d, '0);
        rb(36'h3fffc, word_t'({a, 1'b0}) << 2);
        off(5'h1d, '0);
        rb(36'h3fffc, word_t'({addr_t'(a + 1'b1), 1'b1}) << 2);
        idle(2);
        host.setup(4'h1);
        lat = 3;
        idle(3);
        rd(ad[0]);
        rd(ad[1]);
        off(5'h1f, '0);
        rd(ad[2]);
        idle(3);
        host.setup(4'h0);
        lat = 2;
        idle(2);
        done("byte width and pipelined");
        for (int i = 0; i < 8 && notes.size() > 0; i++) @(negedge clk);
        if (notes.size() > 0) n_mismatch++;
        give_verdict();
    end
endmodule : tb_dp_port_ctrl
